// *** common/btag_pkg.sv ***
package btag_pkg;
	// Command codes
	localparam logic [7:0] BTAG_CMD_READ_SP = 8'h11;
	localparam logic [7:0] BTAG_CMD_WRITE_SP = 8'h17;
	localparam logic [7:0] BTAG_CMD_CP_SP1 = 8'h22;
	localparam logic [7:0] BTAG_CMD_CP_SP2 = 8'h25;
	localparam logic [7:0] BTAG_CMD_CP_SP3 = 8'h28;
	localparam logic [7:0] BTAG_CMD_LD_SP1 = 8'h71;
	localparam logic [7:0] BTAG_CMD_LD_SP2 = 8'h77;
	localparam logic [7:0] BTAG_CMD_LD_SP3 = 8'h7A;
	localparam logic [7:0] BTAG_CMD_LOCK = 8'h43;
	localparam logic [7:0] BTAG_CMD_UNLOCK = 8'h44;
	localparam logic [7:0] BTAG_CMD_CONVERT = 8'hD2;
	localparam logic [7:0] BTAG_CMD_READ_REG = 8'hB2;
	localparam logic [7:0] BTAG_CMD_INC_CYC = 8'hB5;
	localparam logic [7:0] BTAG_CMD_CLR_CYC = 8'hB8;

	// Page map: five 32-byte slots
	localparam int BTAG_PAGE_BYTES = 32;
	localparam int BTAG_SP_BYTES = 96;
	localparam int BTAG_P1_BYTES = 24;
	localparam int BTAG_P2_BYTES = 8;
	localparam int BTAG_P3_BYTES = 32;
	localparam logic [7:0] BTAG_P1_BASE = 8'h00;
	localparam logic [7:0] BTAG_P2_BASE = 8'h20;
	localparam logic [7:0] BTAG_P3_BASE = 8'h40;
	localparam logic [7:0] BTAG_SP_LAST = 8'h5F;
	localparam logic [2:0] BTAG_PAGE_P4 = 3'h3;
	localparam logic [2:0] BTAG_PAGE_P5 = 3'h4;

	// Register offsets
	localparam logic [7:0] BTAG_TEMP_HALF_DEGREE = 8'h60;
	localparam logic [7:0] BTAG_TEMP_SIGNED_DEGREE = 8'h61;
	localparam logic [7:0] BTAG_STATUS_LOW = 8'h62;
	localparam logic [7:0] BTAG_STATUS_HIGH_RESERVED = 8'h63;
	localparam logic [7:0] BTAG_ID_LO = 8'h80;
	localparam logic [7:0] BTAG_ID_HI = 8'h81;
	localparam logic [7:0] BTAG_CYC_LO = 8'h82;
	localparam logic [7:0] BTAG_CYC_HI = 8'h83;

	// Status field positions and fill values
	localparam int BTAG_ST_TB = 0;
	localparam int BTAG_ST_NVB = 1;
	localparam int BTAG_ST_LOCK = 2;
	localparam logic [7:0] BTAG_FILL = 8'hFF;
	localparam logic [7:0] BTAG_ZERO = 8'h00;

	// Timing
	localparam int BTAG_CLK_PERIOD_NS = 20;
	localparam int BTAG_COPY_TIME_US = 10000;
	localparam int BTAG_CONV_TIME_US = 10000;
	localparam int BTAG_COPY_CYC = BTAG_COPY_TIME_US * 1000 / BTAG_CLK_PERIOD_NS;
	localparam int BTAG_CONV_CYC = BTAG_CONV_TIME_US * 1000 / BTAG_CLK_PERIOD_NS;
	localparam int BTAG_CNT_W = 25;

	// Frame states
	typedef enum logic [2:0] {
		BTAG_ST_IDLE,
		BTAG_ST_CMD,
		BTAG_ST_ADDR,
		BTAG_ST_WDATA,
		BTAG_ST_RDATA
	} btag_state_e;

	// Sensor reading pair
	typedef struct packed {
		logic [7:0] signed_deg;
		logic [7:0] half_deg;
	} btag_temp_s;

	// Status byte content
	typedef struct packed {
		logic lock;
		logic persistent_copy_busy;
		logic tb;
	} btag_status_s;
endpackage

// *** hdl/btag_shift.sv ***
`timescale 1ns/1ns
// Bit-serial byte shifter, least significant bit first both ways
module btag_shift (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic frame_start,
	input wire logic rx_valid,
	input wire logic rx_bit,
	input wire logic tx_en,
	input wire logic tx_req,
	input wire logic [7:0] tx_byte,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic tx_byte_done
);
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [2:0] rx_cnt_q, rx_cnt_d;
	logic [2:0] tx_cnt_q, tx_cnt_d;
	logic rbv_q, rbv_d, tb_q, tb_d, tbv_q, tbv_d, tbd_q, tbd_d;

	////////////////////////////////////////////////////////////////
	// Next-state for both directions
	always_comb begin
		rx_sh_d = rx_sh_q;
		rx_cnt_d = rx_cnt_q;
		tx_cnt_d = tx_cnt_q;
		rbv_d = 1'b0;
		tb_d = tb_q;
		tbv_d = 1'b0;
		tbd_d = 1'b0;
		if (frame_start) begin
			rx_cnt_d = 3'h0;
			tx_cnt_d = 3'h0;
		end else begin
			if (rx_valid) begin
				rx_sh_d = {rx_bit, rx_sh_q[7:1]}; // First bit ends at bit 0
				rx_cnt_d = rx_cnt_q + 3'h1;
				rbv_d = (rx_cnt_q == 3'h7);
			end
			if (tx_req && tx_en) begin
				tb_d = tx_byte[tx_cnt_q]; // Bit 0 leaves first
				tbv_d = 1'b1;
				tx_cnt_d = tx_cnt_q + 3'h1;
				tbd_d = (tx_cnt_q == 3'h7);
			end
		end
	end

	// Registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_sh_q <= 8'h00;
			rx_cnt_q <= 3'h0;
			tx_cnt_q <= 3'h0;
			rbv_q <= 1'b0;
			tb_q <= 1'b0;
			tbv_q <= 1'b0;
			tbd_q <= 1'b0;
		end else begin
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			tx_cnt_q <= tx_cnt_d;
			rbv_q <= rbv_d;
			tb_q <= tb_d;
			tbv_q <= tbv_d;
			tbd_q <= tbd_d;
		end
	end

	assign rx_byte_valid = rbv_q;
	assign rx_byte = rx_sh_q;
	assign tx_bit = tb_q;
	assign tx_bit_valid = tbv_q;
	assign tx_byte_done = tbd_q;

	property p_tx_lsb_first;
		@(posedge clk_sys) disable iff (!arst_n)
		(tx_req && tx_en && !frame_start && tx_cnt_q == 3'h0) |=> (tb_q == $past(tx_byte[0]));
	endproperty
	a_tx_lsb_first: assert property (p_tx_lsb_first) else $error("first sent bit is not bit 0");
endmodule

// *** hdl/btag_top.sv ***
`timescale 1ns/1ns
module btag_top
	#(
	parameter int COPY_CYC = btag_pkg::BTAG_COPY_CYC,
	parameter int CONV_CYC = btag_pkg::BTAG_CONV_CYC,
	parameter logic [15:0] ID_WORD = 16'h5A5A // Arbitrary value
	) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic frame_start,
	input wire logic rx_valid,
	input wire logic rx_bit,
	input wire logic tx_req,
	input wire btag_pkg::btag_temp_s sensor_in,
	output logic tx_bit,
	output logic tx_bit_valid,
	output btag_pkg::btag_status_s status_out
);
	import btag_pkg::*;

	logic rx_byte_valid, tx_byte_done;
	logic [7:0] rx_byte, rd_byte;
	btag_state_e st_q, st_d;
	logic [7:0] cmd_q, cmd_d, addr_q, addr_d;
	logic [BTAG_CNT_W-1:0] copy_cnt_q, copy_cnt_d, conv_cnt_q, conv_cnt_d;
	btag_status_s stat_q, stat_d;
	btag_temp_s temp_q, temp_d;
	logic [15:0] cyc_q, cyc_d;
	logic cp1, cp2, cp3, ld1, ld2, ld3, sp_we;
	logic cmd_take, cyc_known_q, cyc_known_d;
	logic [7:0] sp_q [0:BTAG_SP_BYTES-1];
	logic [7:0] nv1_q [0:BTAG_P1_BYTES-1];
	logic [7:0] nv2_q [0:BTAG_P2_BYTES-1];
	logic [7:0] sram_q [0:BTAG_P3_BYTES-1];

	// Implemented scratch addresses of pages one to three
	function automatic logic sp_impl(input logic [7:0] a);
		sp_impl = (a < BTAG_P1_BASE + 8'(BTAG_P1_BYTES))
			|| (a >= BTAG_P2_BASE && a < BTAG_P2_BASE + 8'(BTAG_P2_BYTES))
			|| (a >= BTAG_P3_BASE && a <= BTAG_SP_LAST);
	endfunction

	////////////////////////////////////////////////////////////////
	// Serial byte engine
	btag_shift u_shift (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.frame_start(frame_start),
		.rx_valid(rx_valid),
		.rx_bit(rx_bit),
		.tx_en(st_q == BTAG_ST_RDATA),
		.tx_req(tx_req),
		.tx_byte(rd_byte),
		.rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte),
		.tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid),
		.tx_byte_done(tx_byte_done)
	);

	////////////////////////////////////////////////////////////////
	// Read data mux over the page map
	always_comb begin
		rd_byte = BTAG_FILL;
		if (cmd_q == BTAG_CMD_READ_SP) begin
			if (addr_q <= BTAG_SP_LAST && sp_impl(addr_q)) begin
				rd_byte = sp_q[addr_q[6:0]];
			end
		end else if (cmd_q == BTAG_CMD_READ_REG) begin
			case (addr_q)
				BTAG_TEMP_HALF_DEGREE: rd_byte = temp_q.half_deg;
				BTAG_TEMP_SIGNED_DEGREE: rd_byte = temp_q.signed_deg;
				BTAG_STATUS_LOW: rd_byte = {5'h00, stat_q};
				BTAG_STATUS_HIGH_RESERVED: rd_byte = BTAG_ZERO;
				BTAG_ID_LO: rd_byte = ID_WORD[7:0];
				BTAG_ID_HI: rd_byte = ID_WORD[15:8];
				BTAG_CYC_LO: rd_byte = cyc_q[7:0];
				BTAG_CYC_HI: rd_byte = cyc_q[15:8];
				default: rd_byte = BTAG_FILL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Command framing, flags and counters
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		stat_d = stat_q;
		temp_d = temp_q;
		cyc_d = cyc_q;
		cyc_known_d = cyc_known_q;
		copy_cnt_d = copy_cnt_q;
		conv_cnt_d = conv_cnt_q;
		{cp1, cp2, cp3, ld1, ld2, ld3, sp_we} = 7'h00;
		// Background timers
		if (copy_cnt_q != '0) begin
			copy_cnt_d = copy_cnt_q - BTAG_CNT_W'(1);
		end
		if (copy_cnt_q == BTAG_CNT_W'(1)) begin
			stat_d.persistent_copy_busy = 1'b0;
		end
		if (conv_cnt_q != '0) begin
			conv_cnt_d = conv_cnt_q - BTAG_CNT_W'(1);
		end
		if (conv_cnt_q == BTAG_CNT_W'(1)) begin
			stat_d.tb = 1'b0;
			temp_d = sensor_in;
		end
		if (frame_start) begin
			st_d = BTAG_ST_CMD;
			cmd_d = BTAG_ZERO;
		end else if (rx_byte_valid) begin
			case (st_q)
				BTAG_ST_CMD: begin
					cmd_d = rx_byte;
					st_d = BTAG_ST_IDLE;
					case (rx_byte)
						BTAG_CMD_READ_SP, BTAG_CMD_WRITE_SP, BTAG_CMD_READ_REG: begin
							st_d = BTAG_ST_ADDR;
						end
						BTAG_CMD_CP_SP1: begin
							if (!stat_q.lock) begin
								cp1 = 1'b1;
								stat_d.persistent_copy_busy = 1'b1;
								copy_cnt_d = BTAG_CNT_W'(COPY_CYC);
							end
						end
						BTAG_CMD_CP_SP2: begin
							cp2 = 1'b1;
							stat_d.persistent_copy_busy = 1'b1;
							copy_cnt_d = BTAG_CNT_W'(COPY_CYC);
						end
						BTAG_CMD_CP_SP3: cp3 = 1'b1;
						BTAG_CMD_LD_SP1: ld1 = 1'b1;
						BTAG_CMD_LD_SP2: ld2 = 1'b1;
						BTAG_CMD_LD_SP3: ld3 = 1'b1;
						BTAG_CMD_LOCK: stat_d.lock = 1'b1;
						BTAG_CMD_UNLOCK: stat_d.lock = 1'b0;
						BTAG_CMD_CONVERT: begin
							stat_d.tb = 1'b1;
							conv_cnt_d = BTAG_CNT_W'(CONV_CYC);
						end
						BTAG_CMD_INC_CYC: cyc_d = cyc_q + 16'h0001;
						BTAG_CMD_CLR_CYC: begin
							cyc_d = 16'h0000;
							cyc_known_d = 1'b1; // Counter defined from here on
						end
						default: st_d = BTAG_ST_IDLE; // Undefined codes ignored
					endcase
				end
				BTAG_ST_ADDR: begin
					addr_d = rx_byte;
					st_d = (cmd_q == BTAG_CMD_WRITE_SP) ? BTAG_ST_WDATA : BTAG_ST_RDATA;
				end
				BTAG_ST_WDATA: begin
					sp_we = (addr_q <= BTAG_SP_LAST) && sp_impl(addr_q);
					addr_d = addr_q + 8'h01;
				end
				default: st_d = st_q;
			endcase
		end else if (tx_byte_done && st_q == BTAG_ST_RDATA) begin
			addr_d = addr_q + 8'h01;
		end
	end

	// Volatile control state
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= BTAG_ST_IDLE;
			cmd_q <= 8'h00;
			addr_q <= 8'h00;
			stat_q <= '0;
			temp_q <= '0;
			copy_cnt_q <= '0;
			conv_cnt_q <= '0;
			cyc_known_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			stat_q <= stat_d;
			temp_q <= temp_d;
			copy_cnt_q <= copy_cnt_d;
			conv_cnt_q <= conv_cnt_d;
			cyc_known_q <= cyc_known_d;
		end
	end

	// Persistent cells: no reset, they survive every reset
	always_ff @(posedge clk_sys) begin
		cyc_q <= cyc_d;
	end

	////////////////////////////////////////////////////////////////
	// Scratch bytes: bus writes or whole-page loads from the stores
	for (genvar i = 0; i < BTAG_SP_BYTES; i++) begin : g_mem
		localparam logic [7:0] IA = 8'(i);
		always_ff @(posedge clk_sys) begin
			if (sp_we && addr_q == IA) begin
				sp_q[i] <= rx_byte;
			end else if (ld1 && i < BTAG_P1_BYTES) begin
				sp_q[i] <= nv1_q[i % BTAG_P1_BYTES];
			end else if (ld2 && IA >= BTAG_P2_BASE && i < BTAG_PAGE_BYTES + BTAG_P2_BYTES) begin
				sp_q[i] <= nv2_q[i % BTAG_P2_BYTES];
			end else if (ld3 && IA >= BTAG_P3_BASE) begin
				sp_q[i] <= sram_q[i % BTAG_P3_BYTES];
			end
		end
	end

	// Backing stores, one writer per cell so no cell has two drivers
	for (genvar j = 0; j < BTAG_P1_BYTES; j++) begin : g_nv1
		always_ff @(posedge clk_sys) begin
			if (cp1) begin
				nv1_q[j] <= sp_q[j];
			end
		end
	end
	for (genvar j = 0; j < BTAG_P2_BYTES; j++) begin : g_nv2
		always_ff @(posedge clk_sys) begin
			if (cp2) begin
				nv2_q[j] <= sp_q[BTAG_PAGE_BYTES + j];
			end
		end
	end
	for (genvar j = 0; j < BTAG_P3_BYTES; j++) begin : g_sram
		always_ff @(posedge clk_sys) begin
			if (cp3) begin
				sram_q[j] <= sp_q[2 * BTAG_PAGE_BYTES + j];
			end
		end
	end

	// Status mirror output
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_out <= '0;
		end else begin
			status_out <= stat_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	// Command byte accepted this cycle
	assign cmd_take = (st_q == BTAG_ST_CMD) && rx_byte_valid && !frame_start;

	sequence s_cmd(logic [7:0] c);
		(st_q == BTAG_ST_CMD) && rx_byte_valid && !frame_start && rx_byte == c;
	endsequence

	property p_copy_busy;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_cmd(BTAG_CMD_CP_SP2)) |=> stat_q.persistent_copy_busy [*8];
	endproperty
	a_copy_busy: assert property (p_copy_busy) else $error("copy busy not raised");

	property p_lock_blocks;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_cmd(BTAG_CMD_CP_SP1) and (stat_q.lock && !stat_q.persistent_copy_busy)) |=> !stat_q.persistent_copy_busy;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked page one copy started");

	property p_lock_set;
		@(posedge clk_sys) disable iff (!arst_n)
		s_cmd(BTAG_CMD_LOCK) |=> stat_q.lock ##1 status_out.lock;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag not set");

	property p_inc;
		@(posedge clk_sys) disable iff (!arst_n)
		s_cmd(BTAG_CMD_INC_CYC) |=> cyc_q == $past(cyc_q) + 16'h0001;
	endproperty
	a_inc: assert property (p_inc) else $error("counter did not add one");

	property p_clr;
		@(posedge clk_sys) disable iff (!arst_n)
		s_cmd(BTAG_CMD_CLR_CYC) |=> cyc_q == 16'h0000;
	endproperty
	a_clr: assert property (p_clr) else $error("counter not cleared");

	property p_cyc_stable;
		@(posedge clk_sys) disable iff (!arst_n)
		(cyc_known_q && !(cmd_take && (rx_byte == BTAG_CMD_INC_CYC || rx_byte == BTAG_CMD_CLR_CYC)))
			|=> $stable(cyc_q);
	endproperty
	a_cyc_stable: assert property (p_cyc_stable) else $error("counter changed without command");

	property p_conv_start;
		@(posedge clk_sys) disable iff (!arst_n)
		s_cmd(BTAG_CMD_CONVERT) |=> stat_q.tb && conv_cnt_q != '0;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("conversion busy not raised");

	property p_conv_end;
		@(posedge clk_sys) disable iff (!arst_n)
		(conv_cnt_q == BTAG_CNT_W'(1) && !(cmd_take && rx_byte == BTAG_CMD_CONVERT))
			|=> !stat_q.tb && temp_q == $past(sensor_in);
	endproperty
	a_conv_end: assert property (p_conv_end) else $error("reading not loaded at end");

	property p_status_map;
		@(posedge clk_sys) disable iff (!arst_n)
		(cmd_q == BTAG_CMD_READ_REG && addr_q == BTAG_STATUS_LOW) |-> rd_byte[BTAG_ST_LOCK] == stat_q.lock
			&& rd_byte[BTAG_ST_NVB] == stat_q.persistent_copy_busy && rd_byte[BTAG_ST_TB] == stat_q.tb;
	endproperty
	a_status_map: assert property (p_status_map) else $error("status bits misplaced");
endmodule

// *** verification/btag_master.sv ***
`timescale 1ns/1ns
// Bus master side: frames, command, address and data bytes, read slots
module btag_master (
	input wire logic clk_sys,
	output logic frame_start,
	output logic rx_valid,
	output logic rx_bit,
	output logic tx_req
);
	// Idle levels at time zero
	initial begin
		frame_start = 1'b0;
		rx_valid = 1'b0;
		rx_bit = 1'b1;
		tx_req = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wait whole clock cycles
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One byte, low bit first; data line flips once released
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rx_valid <= 1'b1;
			rx_bit <= b[i];
			@(posedge clk_sys);
		end
		rx_valid <= 1'b0;
		rx_bit <= ~b[7];
		@(posedge clk_sys);
	endtask

	// New frame, then the given command byte, sent as is with no check on its code
	task automatic start(input logic [7:0] c);
		@(posedge clk_sys);
		frame_start <= 1'b1;
		@(posedge clk_sys);
		frame_start <= 1'b0;
		send_byte(c);
	endtask

	// Eight read slots, spaced so the address can advance
	task automatic rd_byte();
		for (int i = 0; i < 8; i++) begin
			tx_req <= 1'b1;
			@(posedge clk_sys);
			tx_req <= 1'b0;
			@(posedge clk_sys);
		end
		idle(2);
	endtask
endmodule

// *** verification/tb_battery_tag_memory_map.sv ***
`timescale 1ns/1ns
// Self-checking bench for the tag memory map
module tb_battery_tag_memory_map;
	import btag_pkg::*;
	localparam int COPY_N = 200;
	localparam int CONV_N = 200;
	localparam logic [15:0] ID_VAL = 16'hC31E; // Arbitrary value
	localparam logic [7:0] PG [3][3] = '{'{BTAG_P1_BASE, BTAG_CMD_CP_SP1, BTAG_CMD_LD_SP1},
		'{BTAG_P2_BASE, BTAG_CMD_CP_SP2, BTAG_CMD_LD_SP2}, '{BTAG_P3_BASE, BTAG_CMD_CP_SP3, BTAG_CMD_LD_SP3}};
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	btag_temp_s sensor_in = '0;
	logic frame_start;
	logic rx_valid;
	logic rx_bit;
	logic tx_req;
	logic tx_bit;
	logic tx_bit_valid;
	btag_status_s status_out;
	logic [7:0] expq[$];
	logic [7:0] sh = 8'h00;
	logic [15:0] lfsr = 16'h6401; // Seed 25601
	int nbit = 0;
	int mismatches = 0;
	int checks = 0;

	// Clock, 20 ns period
	always #10 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	btag_top #(.COPY_CYC(COPY_N), .CONV_CYC(CONV_N), .ID_WORD(ID_VAL)) DUT (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.frame_start(frame_start),
		.rx_valid(rx_valid),
		.rx_bit(rx_bit),
		.tx_req(tx_req),
		.sensor_in(sensor_in),
		.tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid),
		.status_out(status_out)
	);

	btag_master u_mst (
		.clk_sys(clk_sys),
		.frame_start(frame_start),
		.rx_valid(rx_valid),
		.rx_bit(rx_bit),
		.tx_req(tx_req)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Random byte from the shift register
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic summarize();
		if (expq.size() != 0) begin
			mismatches++;
		end
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Read frame; each expected byte is noted before its slots go out
	task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e[$]);
		u_mst.start(c);
		u_mst.send_byte(a);
		u_mst.idle(2);
		foreach (e[i]) begin
			expq.push_back(e[i]);
			u_mst.rd_byte();
		end
	endtask

	// Scratch write frame
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		u_mst.start(BTAG_CMD_WRITE_SP);
		u_mst.send_byte(a);
		foreach (d[i]) u_mst.send_byte(d[i]);
	endtask

	// Status flags at the port shortly after a command byte
	task automatic st(input logic [2:0] e);
		u_mst.idle(2);
		#1;
		chk({5'h00, status_out}, {5'h00, e});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: gather read bits low first, compare against oldest note
	always @(posedge clk_sys) begin
		if (tx_bit_valid === 1'b1) begin
			sh = {tx_bit, sh[7:1]};
			nbit++;
			if (nbit == 8) begin
				nbit = 0;
				if (expq.size() == 0) begin
					mismatches++;
					$display("[ERR] t=%0t got=%h exp=none", $time, sh);
				end else begin
					chk(sh, expq.pop_front());
				end
			end
		end
	end

	// Watchdog
	initial begin
		#(20 * 30000);
		mismatches++;
		summarize();
	end

	// Main sequence
	initial begin
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] k;
		btag_temp_s t;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Counter clear, increments, identity word and fill past the end
		u_mst.start(BTAG_CMD_CLR_CYC);
		rd(BTAG_CMD_READ_REG, BTAG_CYC_LO, '{8'h00, 8'h00});
		repeat (3) u_mst.start(BTAG_CMD_INC_CYC);
		u_mst.rd_byte();
		wr(8'h82, '{8'h55});
		rd(BTAG_CMD_READ_REG, BTAG_ID_LO, '{ID_VAL[7:0], ID_VAL[15:8], 8'h03, 8'h00, 8'hFF});
		// Scratch at page ends; unimplemented places read FFh
		a = rnd();
		b = rnd();
		wr(8'h16, '{a, b, 8'h3C});
		rd(BTAG_CMD_READ_SP, 8'h16, '{a, b, 8'hFF});
		wr(8'h27, '{b, 8'hC3});
		rd(BTAG_CMD_READ_SP, 8'h27, '{b, 8'hFF});
		wr(8'h5E, '{b, a, 8'h5A});
		rd(BTAG_CMD_READ_SP, 8'h5E, '{b, a, 8'hFF});
		// Copy each page to its store, spoil scratch, load back
		for (int p = 0; p < 3; p++) begin
			a = rnd();
			if (p == 0) k = a;
			wr(PG[p][0], '{a});
			u_mst.start(PG[p][1]);
			st((p < 2) ? 3'b010 : 3'b000);
			if (p == 0) rd(BTAG_CMD_READ_REG, BTAG_STATUS_LOW, '{8'h02, 8'h00});
			u_mst.idle(COPY_N);
			st(3'b000);
			wr(PG[p][0], '{~a});
			u_mst.start(PG[p][2]);
			rd(BTAG_CMD_READ_SP, PG[p][0], '{a});
		end
		// Lock blocks the page one store; loading still allowed
		u_mst.start(BTAG_CMD_LOCK);
		st(3'b100);
		wr(BTAG_P1_BASE, '{~k});
		u_mst.start(BTAG_CMD_CP_SP1);
		st(3'b100);
		u_mst.start(BTAG_CMD_LD_SP1);
		rd(BTAG_CMD_READ_SP, BTAG_P1_BASE, '{k});
		u_mst.start(BTAG_CMD_UNLOCK);
		st(3'b000);
		// Conversion: busy while running, reading loaded at the end
		t = {rnd(), rnd()};
		sensor_in <= t;
		u_mst.start(BTAG_CMD_CONVERT);
		st(3'b001);
		rd(BTAG_CMD_READ_REG, BTAG_STATUS_LOW, '{8'h01});
		u_mst.idle(CONV_N);
		sensor_in <= ~t;
		wr(BTAG_TEMP_HALF_DEGREE, '{8'h00});
		rd(BTAG_CMD_READ_REG, BTAG_TEMP_HALF_DEGREE, '{t.half_deg, t.signed_deg, 8'h00, 8'h00, 8'hFF});
		u_mst.idle(20);
		summarize();
	end
endmodule
